// file: hw/occp_channel.sv
// output compare pwm channel with avalon register slave
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/1ps
module occp_channel
	import occp_pkg::*;
(
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              resetn,
	// avalon-mm slave
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// trigger and sync sources, fault pins
	input  wire logic [30:1]       src_event,
	input  wire logic [NFLT-1:0]   fault_pin,
	// cascade chain
	input  wire logic              casc_carry_in,
	output logic                   casc_carry_out,
	// compare output pin
	output logic                   compare_output_pin,
	output logic                   compare_output_oe
);

	occp_state_t s;
	occp_state_t n;

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) begin
			r[7:0] = wd[7:0];
		end
		if (be[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	// legal source codes; reserved ones select nothing
	function automatic logic src_ok(input logic [4:0] c);
		logic ok;
		ok = 1'b0;
		if (c >= 5'h01 && c <= 5'h05) begin
			ok = 1'b1;
		end
		if (c >= 5'h0a && c <= 5'h0f) begin
			ok = 1'b1;
		end
		if (c >= 5'h14 && c <= 5'h1c) begin
			ok = 1'b1;
		end
		if (c == SRC_SELF) begin
			ok = 1'b1;
		end
		return ok;
	endfunction

	logic        req;
	logic        wr;
	logic [2:0]  idx;
	logic [15:0] w16;
	logic [4:0]  code;
	logic        ev;
	logic        tsel;
	logic        held;
	logic        tick;
	logic        inc;
	logic        pwm;
	logic        pstart;
	logic        m1;
	logic        m2;
	logic        factive;
	logic        initp;
	logic [2:0]  nmode;
	logic [1:0]  dcb;
	logic        dwave;

	assign req         = read | write;
	assign waitrequest = req & ~s.ack;
	assign readdata    = s.rdata;
	assign casc_carry_out     = s.cout;
	assign compare_output_pin = s.pin;
	assign compare_output_oe  = s.oe;

	always_comb begin
		n = s;
		idx = address[4:2];
		wr = s.ack & write;
		w16 = 16'h0000;
		initp = 1'b0;
		nmode = s.mode;
		n.ack = req & ~s.ack;
		n.cout = 1'b0;
		// bus read data prepared in the wait cycle
		n.rdata = 32'h0000_0000;
		unique case (idx)
			IDX_CTRL1: n.rdata[9:0] = {s.fen, s.fflag, s.tclr, s.mode};
			IDX_CTRL2: n.rdata[15:0] = s.c2;
			IDX_PRI:   n.rdata[15:0] = s.pri;
			IDX_SEC:   n.rdata[15:0] = s.sec;
			IDX_PER:   n.rdata[15:0] = s.per;
			IDX_TMR:   n.rdata[15:0] = s.tmr;
			IDX_STAT:  n.rdata[4:0] = {s.oe, s.done, s.dn, s.flt, s.pin};
			default:   n.rdata = 32'h0000_0000;
		endcase
		// fault pin synchronisers
		n.f1 = fault_pin;
		n.f2 = s.f1;
		factive = |(s.f2 & s.fen);
		// register writes
		if (wr) begin
			unique case (idx)
				IDX_CTRL1: begin
					w16 = lane_merge({6'h00, s.fen, s.fflag, s.tclr, s.mode},
						writedata, byteenable);
					nmode = w16[2:0];
					n.tclr = w16[C1_TCLR];
					n.fen = w16[C1_FEN +: 3];
					n.fflag = s.fflag & w16[C1_FFLAG +: 3];
					initp = nmode != s.mode;
				end
				IDX_CTRL2: begin
					w16 = lane_merge(s.c2, writedata, byteenable);
					n.c2 = w16 & CTRL2_WMASK;
				end
				IDX_PRI: n.pri = lane_merge(s.pri, writedata, byteenable);
				IDX_SEC: n.sec = lane_merge(s.sec, writedata, byteenable);
				IDX_PER: n.per = lane_merge(s.per, writedata, byteenable);
				default: n.mode = s.mode;
			endcase
		end
		n.mode = nmode;
		pwm = s.mode == MODE_EPWM || s.mode == MODE_CPWM;
		// source selection
		code = s.c2[4:0];
		tsel = s.c2[C2_TSEL];
		ev = 1'b0;
		if (code == SRC_SELF) begin
			ev = s.cout;
		end else if (src_ok(code)) begin
			ev = src_event[code];
		end
		// instruction cycle prescaler
		tick = s.ph == 2'(ICYC_CLKS - 1);
		n.ph = s.ph + 2'h1;
		inc = s.c2[C2_CASC] ? casc_carry_in : tick;
		held = tsel & ~s.c2[C2_TSTAT];
		m1 = inc & (s.tmr == s.pri);
		m2 = inc & (s.tmr == s.sec);
		pstart = 1'b0;
		// channel timer
		if (s.mode == MODE_OFF || held) begin
			n.tmr = 16'h0000;
			n.dn = 1'b0;
		end else if (~tsel && code != SRC_NONE && ev) begin
			n.tmr = 16'h0000;
			n.dn = 1'b0;
		end else if (inc) begin
			if (s.mode == MODE_CPWM) begin
				if (!s.dn) begin
					if (s.tmr >= s.per) begin
						n.dn = s.per != 16'h0000;
						n.tmr = s.per == 16'h0000 ? 16'h0000 : s.tmr - 16'h0001;
						pstart = s.per == 16'h0000;
					end else begin
						n.tmr = s.tmr + 16'h0001;
					end
				end else if (s.tmr <= 16'h0001) begin
					n.tmr = 16'h0000;
					n.dn = 1'b0;
					pstart = 1'b1;
				end else begin
					n.tmr = s.tmr - 16'h0001;
				end
			end else if (s.tmr == s.per) begin
				n.tmr = 16'h0000;
				pstart = 1'b1;
			end else begin
				n.tmr = s.tmr + 16'h0001;
			end
		end
		n.cout = pstart;
		// trigger flag: software write, auto clear, then set wins
		if (tsel && s.tclr && s.tmr == s.sec) begin
			n.c2[C2_TSTAT] = 1'b0;
		end
		if (tsel && ev && s.mode != MODE_OFF) begin
			n.c2[C2_TSTAT] = 1'b1;
		end
		// duty buffers
		if (!pwm || pstart) begin
			n.pri_b = s.pri;
			n.sec_b = s.sec;
			n.dcb_b = s.c2[C2_DCB +: 2];
		end
		// compare waveform
		unique case (s.mode)
			MODE_OFF: begin
				n.wave = 1'b0;
				n.done = 1'b0;
			end
			MODE_SS_HI: if (m1 && !s.done) begin
				n.wave = 1'b1;
				n.done = 1'b1;
			end
			MODE_SS_LO: if (m1 && !s.done) begin
				n.wave = 1'b0;
				n.done = 1'b1;
			end
			MODE_TOG: if (m1) begin
				n.wave = ~s.wave;
			end
			MODE_DSS: begin
				if (m1 && !s.done) begin
					n.wave = 1'b1;
				end
				if (m2 && s.wave) begin
					n.wave = 1'b0;
					n.done = 1'b1;
				end
			end
			MODE_DCP: begin
				if (m1) begin
					n.wave = 1'b1;
				end
				if (m2) begin
					n.wave = 1'b0;
				end
			end
			MODE_EPWM, MODE_CPWM: begin
				n.wave = s.tmr >= s.pri_b && s.tmr < s.sec_b;
			end
		endcase
		if (initp) begin
			n.wave = nmode == MODE_SS_LO;
			n.done = 1'b0;
		end
		// fault flags and fault state
		if (s.mode == MODE_CPWM) begin
			n.fflag = n.fflag | (s.f2 & s.fen);
		end
		if (!pwm) begin
			n.flt = 1'b0;
		end else if (factive) begin
			n.flt = 1'b1;
		end else if (s.flt) begin
			if (s.c2[C2_FAULT_LATCH_SELECT]) begin
				n.flt = s.mode == MODE_CPWM && (s.fflag & s.fen) != 3'h0;
			end else begin
				n.flt = ~pstart;
			end
		end
		// sub-cycle falling edge delay
		dcb = pwm ? s.dcb_b : s.c2[C2_DCB +: 2];
		if (s.mode == MODE_SS_HI) begin
			dcb = 2'h0;
		end
		if (s.dly != 2'h0) begin
			n.dly = s.dly - 2'h1;
		end
		if (s.wave && !n.wave) begin
			n.dly = dcb;
		end
		dwave = s.wave | (s.dly != 2'h0);
		// pin drive
		n.pin = s.flt ? s.c2[C2_FOUT] : dwave ^ s.c2[C2_INV];
		n.oe = ~s.c2[C2_TRIS] | (s.flt & s.c2[C2_FDIR]);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			s <= '{ack: 1'b0, rdata: 32'h0000_0000, mode: MODE_OFF,
				tclr: 1'b0, fen: 3'h0, fflag: 3'h0, c2: CTRL2_RST,
				pri: VAL_RST, sec: VAL_RST, per: VAL_RST,
				pri_b: VAL_RST, sec_b: VAL_RST, dcb_b: 2'h0,
				tmr: VAL_RST, dn: 1'b0, ph: 2'h0, f1: 3'h0, f2: 3'h0,
				flt: 1'b0, wave: 1'b0, done: 1'b0, dly: 2'h0,
				pin: 1'b0, oe: 1'b1, cout: 1'b0};
		end else begin
			s <= n;
		end
	end

endmodule

// file: hw/occp_pkg.sv
// constants and state layout for the output compare pwm channel
package occp_pkg;
	localparam int         ADDR_W      = 5;
	localparam logic [2:0] IDX_CTRL1   = 3'h0;
	localparam logic [2:0] IDX_CTRL2   = 3'h1;
	localparam logic [2:0] IDX_PRI     = 3'h2;
	localparam logic [2:0] IDX_SEC     = 3'h3;
	localparam logic [2:0] IDX_PER     = 3'h4;
	localparam logic [2:0] IDX_TMR     = 3'h5;
	localparam logic [2:0] IDX_STAT    = 3'h6;
	localparam int         C1_TCLR     = 3;
	localparam int         C1_FFLAG    = 4;
	localparam int         C1_FEN      = 7;
	localparam int         C2_FAULT_LATCH_SELECT    = 15;
	localparam int         C2_FOUT     = 14;
	localparam int         C2_FDIR     = 13;
	localparam int         C2_INV      = 12;
	localparam int         C2_DCB      = 9;
	localparam int         C2_CASC     = 8;
	localparam int         C2_TSEL     = 7;
	localparam int         C2_TSTAT    = 6;
	localparam int         C2_TRIS     = 5;
	localparam logic [15:0] CTRL2_RST  = 16'h000c;
	localparam logic [15:0] CTRL2_WMASK = 16'hf7ff;
	localparam logic [15:0] VAL_RST    = 16'h0000;
	localparam logic [2:0] MODE_OFF    = 3'h0;
	localparam logic [2:0] MODE_SS_HI  = 3'h1;
	localparam logic [2:0] MODE_SS_LO  = 3'h2;
	localparam logic [2:0] MODE_TOG    = 3'h3;
	localparam logic [2:0] MODE_DSS    = 3'h4;
	localparam logic [2:0] MODE_DCP    = 3'h5;
	localparam logic [2:0] MODE_EPWM   = 3'h6;
	localparam logic [2:0] MODE_CPWM   = 3'h7;
	localparam logic [4:0] SRC_NONE    = 5'h00;
	localparam logic [4:0] SRC_SELF    = 5'h1f;
	localparam int         MCLK_NS     = 20;
	localparam int         ICYC_NS     = 80;
	localparam int         ICYC_CLKS   = ICYC_NS / MCLK_NS;
	localparam int         NFLT        = 3;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
		logic [2:0]  mode;
		logic        tclr;
		logic [2:0]  fen;
		logic [2:0]  fflag;
		logic [15:0] c2;
		logic [15:0] pri;
		logic [15:0] sec;
		logic [15:0] per;
		logic [15:0] pri_b;
		logic [15:0] sec_b;
		logic [1:0]  dcb_b;
		logic [15:0] tmr;
		logic        dn;
		logic [1:0]  ph;
		logic [2:0]  f1;
		logic [2:0]  f2;
		logic        flt;
		logic        wave;
		logic        done;
		logic [1:0]  dly;
		logic        pin;
		logic        oe;
		logic        cout;
	} occp_state_t;
endpackage

// file: testbench/occp_channel_asserts.sv
// concurrent checks on the channel ports
`timescale 1ns/1ps
module occp_channel_asserts
	import occp_pkg::*;
(
	// clock, reset and bus
	input wire logic              mclk,
	input wire logic              resetn,
	input wire logic [ADDR_W-1:0] address,
	input wire logic              read,
	input wire logic              write,
	input wire logic [31:0]       writedata,
	input wire logic [31:0]       readdata,
	input wire logic              waitrequest,
	// fault and pin
	input wire logic [NFLT-1:0]   fault_pin,
	input wire logic              compare_output_pin,
	input wire logic              compare_output_oe
);
	logic [2:0]  mode_reg;
	logic        fen_reg;
	logic [15:0] c2_reg;
	logic [3:0]  st_reg;
	logic        wr, ok, fa;
	assign wr = write & ~waitrequest;
	assign ok = st_reg[3];
	assign fa = fault_pin[0] & fen_reg & (&mode_reg[2:1]) & ok;
	// shadow of control bits, settle count since last write
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= MODE_OFF;
			fen_reg  <= 1'b0;
			c2_reg   <= CTRL2_RST;
			st_reg   <= 4'h0;
		end else begin
			st_reg <= wr ? 4'h0 : st_reg + {3'h0, ~ok};
			if (wr && address[4:2] == IDX_CTRL1) begin
				mode_reg <= writedata[2:0];
				fen_reg  <= writedata[C1_FEN];
			end
			if (wr && address[4:2] == IDX_CTRL2)
				c2_reg <= writedata[15:0] & CTRL2_WMASK;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	AST_WAIT: assert property ($rose(read | write) |->
		waitrequest ##1 !waitrequest) else $error("bus answer late");
	AST_UNMAPPED: assert property (read && !waitrequest &&
		address[4:2] == 3'h7 |-> readdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_OFF: assert property (ok && mode_reg == MODE_OFF |->
		$stable(compare_output_pin)) else $error("pin moved when off");
	AST_SS_HI: assert property (ok && mode_reg == MODE_SS_HI &&
		!c2_reg[C2_INV] && $past(compare_output_pin) |->
		compare_output_pin) else $error("single shot high lost");
	AST_SS_LO: assert property (ok && mode_reg == MODE_SS_LO &&
		!c2_reg[C2_INV] && !$past(compare_output_pin) |->
		!compare_output_pin) else $error("single shot low lost");
	AST_TRIS: assert property (ok && !c2_reg[C2_FDIR] |->
		compare_output_oe == !c2_reg[C2_TRIS]) else $error("pin enable");
	AST_FLT_LVL: assert property (fa [*6] |->
		compare_output_pin == c2_reg[C2_FOUT]) else $error("fault level");
	AST_FLT_OE: assert property (fa [*6] && c2_reg[C2_FDIR] |->
		compare_output_oe) else $error("fault enable");
	cover property (fa [*6]);
	cover property (mode_reg == MODE_CPWM && $rose(compare_output_pin));
	cover property (read && !waitrequest && address[4:2] == 3'h7);
endmodule
bind occp_channel occp_channel_asserts occp_channel_asserts_i (
	.mclk(mclk), .resetn(resetn), .address(address), .read(read),
	.write(write), .writedata(writedata), .readdata(readdata),
	.waitrequest(waitrequest), .fault_pin(fault_pin),
	.compare_output_pin(compare_output_pin),
	.compare_output_oe(compare_output_oe));

// file: testbench/occp_channel_bench.sv
// self-checking bench for the compare channel
`timescale 1ns/1ps
module occp_channel_bench
	import occp_pkg::*;
;
	logic              mclk = 1'b0;
	logic              resetn = 1'b0;
	logic              read = 1'b0;
	logic              write = 1'b0;
	logic              kick = 1'b0;
	logic              casc_carry_in = 1'b0;
	logic [ADDR_W-1:0] address = '0;
	logic [31:0]       writedata = '0;
	logic [NFLT-1:0]   fault_pin = '0;
	logic [30:1]       src_event = '0;
	logic [31:0]       readdata, rd;
	logic              waitrequest, casc_carry_out, pin, oe, level, inv;
	logic [30:0]       r;
	logic [15:0]       d;
	logic [2:0]        m;
	integer            seed = 32'h43a3c9fe;
	int                n_mismatch = 0;
	int                total_checks = 0;
	int                edges;
	int                n_high;
	int                n_carry;
	always #10 mclk = ~mclk;
	occp_channel occp_channel_i (.mclk(mclk), .resetn(resetn),
		.address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata),
		.waitrequest(waitrequest), .src_event(src_event),
		.fault_pin(fault_pin), .casc_carry_in(casc_carry_in),
		.casc_carry_out(casc_carry_out), .compare_output_pin(pin),
		.compare_output_oe(oe));
	occp_load_model occp_load_model_i (.pin(pin), .oe(oe), .level(level));
	// random source pulses, selected trigger bit under control
	always @(posedge mclk) begin
		r = 31'($random(seed));
		r[11] = kick;
		src_event <= r[30:1];
		casc_carry_in <= r[0];
	end
	task conclude;
		if (n_mismatch == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] e, input logic [31:0] g, input string nm);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task acc(input logic w, input logic [2:0] i, input logic [15:0] v);
		@(posedge mclk);
		read <= ~w;
		write <= w;
		address <= {i, 2'b00};
		writedata <= {16'h0000, v};
		do begin
			@(posedge mclk);
		end while (waitrequest !== 1'b0);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task cnt(input int n);
		logic p;
		edges = 0;
		n_high = 0;
		n_carry = 0;
		p = pin;
		repeat (n) begin
			@(posedge mclk);
			if (pin !== p)
				edges++;
			if (pin === 1'b1)
				n_high++;
			if (casc_carry_out === 1'b1)
				n_carry++;
			p = pin;
		end
	endtask
	// pin changes in 360 cycles with pri 2, sec 5, period 9
	function automatic int exp_edges(input logic [2:0] md);
		case (md)
			MODE_OFF: return 0;
			MODE_SS_HI, MODE_SS_LO: return 1;
			MODE_DSS: return 2;
			MODE_TOG: return 9;
			default: return 18;
		endcase
	endfunction
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		$display("unexpected watchdog expected finish seen timeout");
		conclude();
	end
	initial begin
		repeat (12) @(posedge mclk);
		resetn <= 1'b1;
		acc(1'b0, IDX_CTRL2, 16'h0000);
		chk({16'h0000, CTRL2_RST}, rd, "ctrl2 reset");
		acc(1'b1, 3'h7, 16'hffff);
		acc(1'b0, 3'h7, 16'h0000);
		chk(32'h0000_0000, rd, "unmapped");
		repeat (4) begin
			d = 16'($random(seed));
			d[4:0] = SRC_NONE;
			acc(1'b1, IDX_CTRL2, d);
			acc(1'b0, IDX_CTRL2, 16'h0000);
			chk({16'h0000, d & CTRL2_WMASK}, rd, "ctrl2");
		end
		acc(1'b1, IDX_PRI, 16'h0002);
		acc(1'b1, IDX_SEC, 16'h0005);
		acc(1'b1, IDX_PER, 16'h0009);
		acc(1'b0, IDX_SEC, 16'h0000);
		chk(32'h0000_0005, rd, "secondary");
		for (int i = 0; i < 9; i++) begin
			m = (i == 8) ? MODE_SS_HI : i[2:0];
			inv = (i == 8);
			acc(1'b1, IDX_CTRL2, {3'h0, inv, 12'h08b});
			acc(1'b1, IDX_CTRL1, {13'h0000, m});
			acc(1'b0, IDX_TMR, 16'h0000);
			chk(32'h0000_0000, rd, "held timer");
			@(posedge mclk);
			kick <= 1'b1;
			@(posedge mclk);
			kick <= 1'b0;
			cnt(360);
			if (m == MODE_CPWM)
				chk(1, edges != 0, "center edges");
			else
				chk(exp_edges(m), edges, "edges");
			if (m == MODE_SS_HI || m == MODE_SS_LO)
				chk(m[0] ^ inv, pin, "final level");
			acc(1'b0, IDX_CTRL2, 16'h0000);
			chk(m != MODE_OFF, rd[C2_TSTAT], "trigger flag");
		end
		// pulse of 3 ticks stretched by 3 clocks, plain then inverted
		for (int k = 0; k < 2; k++) begin
			acc(1'b1, IDX_CTRL2, k ? 16'h1600 : 16'h0600);
			acc(1'b1, IDX_CTRL1, {13'h0000, MODE_EPWM});
			repeat (80) @(posedge mclk);
			cnt(360);
			chk(k ? 225 : 135, n_high, "stretched high time");
			chk(9, n_carry, "carry pulses");
		end
		// trigger clear mode drops the flag at the secondary match
		acc(1'b1, IDX_CTRL2, 16'h008b);
		acc(1'b1, IDX_CTRL1, {12'h000, 1'b1, MODE_TOG});
		repeat (8) @(posedge mclk);
		kick <= 1'b1;
		@(posedge mclk);
		kick <= 1'b0;
		cnt(60);
		chk(1, edges, "toggle before clear");
		acc(1'b0, IDX_CTRL2, 16'h0000);
		chk(0, rd[C2_TSTAT], "trigger clear");
		// unlatched fault in edge pwm, then latched in center pwm
		acc(1'b1, IDX_CTRL2, 16'h6020);
		acc(1'b1, IDX_CTRL1, 16'h0086);
		fault_pin <= 3'h1;
		repeat (20) @(posedge mclk);
		chk(1, level, "fault level");
		fault_pin <= 3'h0;
		repeat (100) @(posedge mclk);
		chk(0, oe, "released pin");
		acc(1'b1, IDX_CTRL2, 16'he020);
		acc(1'b1, IDX_CTRL1, 16'h0087);
		fault_pin <= 3'h1;
		repeat (20) @(posedge mclk);
		acc(1'b0, IDX_CTRL1, 16'h0000);
		chk(32'h0000_0097, rd, "fault flag");
		fault_pin <= 3'h0;
		repeat (200) @(posedge mclk);
		chk(1, level, "latched fault");
		acc(1'b1, IDX_CTRL1, 16'h0087);
		repeat (200) @(posedge mclk);
		chk(0, oe, "fault cleared");
		conclude();
	end
endmodule

// file: testbench/occp_load_model.sv
// external load on the compare output pin
`timescale 1ns/1ps
module occp_load_model (
	// pin side
	input  wire logic pin,
	input  wire logic oe,
	// level seen by the load
	output logic      level
);
	// released pin falls to the pull-down
	assign level = oe ? pin : 1'b0;
endmodule
